/* File: tlic_core_model.sv */
// behavioural core beside the controller: ready, return pulse, push depth
// assumes the controller's clock and reset
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
    // clock and reset
    input wire logic  mclk,
    input wire logic  arst_n,
    // bench commands
    input wire logic  ret_req,
    input wire logic  stall,
    // controller side
    input wire logic  push_pc,
    output logic      core_ready,
    output logic      reti_pulse,
    output logic [3:0] depth
);
    // a stalled core keeps every request waiting
    assign core_ready = ~stall;
    // pushes deepen the stack, returns unwind it
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reti_pulse <= 1'b0;
            depth      <= 4'h0;
        end else begin
            reti_pulse <= ret_req;
            depth      <= depth + {3'h0, push_pc} - {3'h0, ret_req};
        end
    end
endmodule
`default_nettype wire

/* File: tlic_pkg.sv */
// package for the two level interrupt controller: register map, fields, vectors
// assumes a core that reads an 8-bit special register space over a plain port
// Behaviour
// (RULE1) eleven sources arbitrated over two priority levels, high and low
// (RULE2) main enable: bit 7 global, then adc, t2, uart, t1, ext1, t0, ext0
// (RULE3) main priority: bits 6..0 adc down to ext0; bit 7 reserved; 1 is high
// (RULE4) secondary: priorities of interval, supply, serial2 at 6..4, enables at 2..0
// (RULE5) software keeps bit 3 of the secondary register at zero
// (RULE6) reset values: secondary a0, main enable and main priority zero
// (RULE7) an enabled high request may preempt a low routine in service
// (RULE8) same-cycle requests of both levels: the high one is taken first
// (RULE9) no preemption by a request of the same level; it waits for return
// (RULE10) equal level ties follow a fixed poll order, supply monitor first
// (RULE11) on acceptance the core is told to push the program counter
// (RULE12) each source has its own fixed vector address loaded into the counter
// (RULE13) with interrupt mode set, a watchdog timeout interrupts instead of resetting
// (RULE14) watchdog is always high priority and ignores the global enable
// (RULE15) watchdog interrupts only when its timeout setting is above zero
// (RULE16) active levels are tracked and released on return from interrupt
package tlic_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_IE_MAIN  = 8'ha8;
    localparam logic [7:0] ADDR_IE_SEC   = 8'ha9;
    localparam logic [7:0] ADDR_IP_MAIN  = 8'hb8;
    localparam logic [7:0] ADDR_STATUS   = 8'hc0;
    localparam logic [7:0] ADDR_MASK     = 8'hc1;
    localparam logic [7:0] RST_IE_MAIN   = 8'h00;
    localparam logic [7:0] RST_IE_SEC    = 8'ha0;
    localparam logic [7:0] RST_IP_MAIN   = 8'h00;
    localparam logic [7:0] MASK_IP_MAIN  = 8'h7f;
    localparam logic [7:0] MASK_IE_SEC   = 8'h77;
    localparam logic [7:0] MASK_STATUS   = 8'h07;
    localparam int         BIT_GLOBAL    = 7;
    // ************************************************************
    // source indices in poll order, 0 polls first
    // ************************************************************
    localparam int NSRC      = 11;
    localparam int S_PSM     = 0;
    localparam int S_WDOG    = 1;
    localparam int S_EXT0    = 2;
    localparam int S_ADC     = 3;
    localparam int S_T0      = 4;
    localparam int S_EXT1    = 5;
    localparam int S_T1      = 6;
    localparam int S_SER2    = 7;
    localparam int S_UART    = 8;
    localparam int S_T2      = 9;
    localparam int S_TIC     = 10;
    // status event bits
    localparam int EV_TAKE   = 0;
    localparam int EV_PREEMPT= 1;
    localparam int EV_WDOG   = 2;
    // vector addresses indexed by poll position
    localparam logic [15:0] VEC_TABLE [NSRC] = '{
        16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
        16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
    localparam logic [3:0] SRC_NONE = 4'hf;
endpackage

/* File: tlic_poll.sv */
// fixed order poll: lowest index with a request wins
// assumes a request vector built in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tlic_poll #(
    parameter int N = 11
) (
    // requests
    input  wire logic [N-1:0] req,
    // winner
    output logic              found,
    output logic [3:0]        idx
);
    // scan downward so the lowest index is left last
    always_comb begin
        found = 1'b0;
        idx   = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                found = 1'b1; // RULE10
                idx   = 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

/* File: tlic_top.sv */
// two level interrupt controller: enables, priorities, poll, vector, nesting
// assumes the core is synchronous to mclk, takes irq_take as a one cycle pulse,
// and pulses reti_pulse when it executes return from interrupt
// assumes each flag stays high until the core's handler clears it
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tlic_top #(
    parameter int WDOG_TW = 4
) (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               arst_n,
    input  wire logic               clk_en,

    // register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,

    // peripheral flags
    input  wire logic               supply_monitor_flag,
    input  wire logic               watchdog_timeout_flag,
    input  wire logic               watchdog_interrupt_mode,
    input  wire logic [WDOG_TW-1:0] watchdog_timeout_setting,
    input  wire logic               ext0_request_flag,
    input  wire logic               primary_adc_ready_flag,
    input  wire logic               aux_adc_ready_flag,
    input  wire logic               timer0_overflow_flag,
    input  wire logic               ext1_request_flag,
    input  wire logic               timer1_overflow_flag,
    input  wire logic               spi_transfer_flag,
    input  wire logic               twowire_transfer_flag,
    input  wire logic               uart_rx_done_flag,
    input  wire logic               uart_tx_done_flag,
    input  wire logic               timer2_overflow_flag,
    input  wire logic               timer2_external_flag,
    input  wire logic               interval_counter_flag,

    // core handshake
    input  wire logic               core_ready,
    input  wire logic               reti_pulse,
    output logic                    irq_take,
    output logic                    push_pc,
    output logic [15:0]             vector_addr,
    output logic [3:0]              src_index,
    output logic                    wdog_reset_req,
    output logic                    in_high,
    output logic                    in_low,
    output logic                    irq_out
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_JUMP = 2'b10
    } tlic_phase_t;

    typedef struct packed {
        // software registers
        logic [7:0]  ie_main;
        logic [7:0]  ie_sec;
        logic [7:0]  ip_main;

        // event status and its mask
        logic [7:0]  status;
        logic [7:0]  mask;

        // read data slot
        logic [7:0]  rdata;

        // sequencer and levels in service
        tlic_phase_t phase;
        logic        act_hi;
        logic        act_lo;

        // strobes to the core
        logic        take;
        logic        push;

        // chosen source and vector
        logic [15:0] vec;
        logic [3:0]  src;
        logic        pend_hi;

        // level outputs
        logic        wdrst;
        logic        irq;
    } tlic_state_t;

    // current and next copy of all state
    tlic_state_t s_q;
    tlic_state_t s_d;

    // ************************************************************
    // request and level assembly
    // ************************************************************
    // per source, in poll order
    logic [10:0] raw;
    logic [10:0] en;
    logic [10:0] hi;
    logic [10:0] req_hi;
    logic [10:0] req_lo;

    // winner of each level
    logic        f_hi;
    logic        f_lo;
    // poll index of each winner
    logic [3:0]  i_hi;
    logic [3:0]  i_lo;

    // watchdog may interrupt
    logic        wdog_arm;

    // timeout of zero never interrupts
    // a zero setting takes the reset path
    assign wdog_arm = watchdog_interrupt_mode && (watchdog_timeout_setting != '0); // RULE15

    // shared flags combine into one source each
    // the handler must clear both flags of a pair
    always_comb begin
        raw               = '0;
        raw[tlic_pkg::S_PSM]  = supply_monitor_flag;
        raw[tlic_pkg::S_WDOG] = watchdog_timeout_flag && wdog_arm; // RULE13
        raw[tlic_pkg::S_EXT0] = ext0_request_flag;
        raw[tlic_pkg::S_ADC]  = primary_adc_ready_flag | aux_adc_ready_flag;
        raw[tlic_pkg::S_T0]   = timer0_overflow_flag;
        raw[tlic_pkg::S_EXT1] = ext1_request_flag;
        raw[tlic_pkg::S_T1]   = timer1_overflow_flag;
        raw[tlic_pkg::S_SER2] = spi_transfer_flag | twowire_transfer_flag;
        raw[tlic_pkg::S_UART] = uart_rx_done_flag | uart_tx_done_flag;
        raw[tlic_pkg::S_T2]   = timer2_overflow_flag | timer2_external_flag;
        raw[tlic_pkg::S_TIC]  = interval_counter_flag;
    end

    // enables and priorities mapped from register bits
    always_comb begin
        en                    = '0;
        hi                    = '0;
        // main enable bits
        en[tlic_pkg::S_EXT0]  = s_q.ie_main[0]; // RULE2
        en[tlic_pkg::S_T0]    = s_q.ie_main[1];
        en[tlic_pkg::S_EXT1]  = s_q.ie_main[2];
        en[tlic_pkg::S_T1]    = s_q.ie_main[3];
        en[tlic_pkg::S_UART]  = s_q.ie_main[4];
        en[tlic_pkg::S_T2]    = s_q.ie_main[5];
        en[tlic_pkg::S_ADC]   = s_q.ie_main[6];

        // secondary enable bits
        en[tlic_pkg::S_SER2]  = s_q.ie_sec[0]; // RULE4
        en[tlic_pkg::S_PSM]   = s_q.ie_sec[1];
        en[tlic_pkg::S_TIC]   = s_q.ie_sec[2];

        // main priority bits
        hi[tlic_pkg::S_EXT0]  = s_q.ip_main[0]; // RULE3
        hi[tlic_pkg::S_T0]    = s_q.ip_main[1];
        hi[tlic_pkg::S_EXT1]  = s_q.ip_main[2];
        hi[tlic_pkg::S_T1]    = s_q.ip_main[3];
        hi[tlic_pkg::S_UART]  = s_q.ip_main[4];
        hi[tlic_pkg::S_T2]    = s_q.ip_main[5];
        hi[tlic_pkg::S_ADC]   = s_q.ip_main[6];

        // secondary priority bits
        hi[tlic_pkg::S_SER2]  = s_q.ie_sec[4]; // RULE4
        hi[tlic_pkg::S_PSM]   = s_q.ie_sec[5];
        hi[tlic_pkg::S_TIC]   = s_q.ie_sec[6];
        hi[tlic_pkg::S_WDOG]  = 1'b1; // RULE14
        // global enable gates all but the watchdog
        en = en & {11{s_q.ie_main[tlic_pkg::BIT_GLOBAL]}};
        en[tlic_pkg::S_WDOG]  = 1'b1; // RULE14
    end

    // flag, enable and matching level
    assign req_hi = raw & en & hi;  // RULE1
    assign req_lo = raw & en & ~hi;

    // ************************************************************
    // poll instances, one per level
    // ************************************************************
    // level test first, poll order second
    tlic_poll #(.N(tlic_pkg::NSRC)) u_poll_hi (
        .req   (req_hi),
        .found (f_hi),
        .idx   (i_hi)
    );

    tlic_poll #(.N(tlic_pkg::NSRC)) u_poll_lo (
        .req   (req_lo),
        .found (f_lo),
        .idx   (i_lo)
    );

    // masked write for registers with reserved bits
    // reserved positions store zero after every write; secondary bit 7 keeps its reset one until then
    function automatic logic [7:0] wmask(input logic [7:0] v, input logic [7:0] m);
        return v & m;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic can_hi;
        logic can_lo;
        logic [7:0] ev;
        can_hi = 1'b0;
        can_lo = 1'b0;
        ev     = '0;
        // hold by default; strobes drop to zero
        s_d    = s_q;
        s_d.take  = 1'b0;
        s_d.push  = 1'b0;
        s_d.rdata = '0;
        // reset request when it may not interrupt
        s_d.wdrst = watchdog_timeout_flag && !wdog_arm; // RULE13

        // high may enter over a low routine, never over another high
        can_hi = f_hi && !s_q.act_hi;               // RULE7 RULE9
        can_lo = f_lo && !s_q.act_hi && !s_q.act_lo; // RULE9

        // return releases the innermost level first
        // a high level always sits over a low one
        if (reti_pulse) begin
            if (s_q.act_hi) begin
                s_d.act_hi = 1'b0; // RULE16
            end else begin
                s_d.act_lo = 1'b0; // RULE16
            end
        end

        // decide, push, jump, then one gap cycle
        // the gap lets the core fetch the vector
        case (s_q.phase)
            ST_IDLE: begin
                // a return in flight blocks the decision
                if (core_ready && !reti_pulse && (can_hi || can_lo)) begin
                    // high wins over low arriving together
                    if (can_hi) begin // RULE8
                        s_d.src     = i_hi;
                        s_d.pend_hi = 1'b1;
                        if (s_q.act_lo) begin
                            ev[tlic_pkg::EV_PREEMPT] = 1'b1;
                        end
                    end else begin
                        // low only with no level in service
                        s_d.src     = i_lo;
                        s_d.pend_hi = 1'b0;
                    end
                    s_d.push  = 1'b1; // RULE11
                    s_d.phase = ST_PUSH;
                end
            end
            ST_PUSH: begin
                // vector and level land with the take
                s_d.vec   = tlic_pkg::VEC_TABLE[s_q.src]; // RULE12
                s_d.take  = 1'b1;
                s_d.phase = ST_JUMP;
                ev[tlic_pkg::EV_TAKE] = 1'b1;
                if (s_q.src == 4'(tlic_pkg::S_WDOG)) begin
                    ev[tlic_pkg::EV_WDOG] = 1'b1;
                end
                if (s_q.pend_hi) begin
                    s_d.act_hi = 1'b1; // RULE16
                end else begin
                    s_d.act_lo = 1'b1; // RULE16
                end
            end
            ST_JUMP: begin
                // gap cycle, nothing decided
                s_d.phase = ST_IDLE;
            end
            default: begin
                // unused code back to idle
                s_d.phase = ST_IDLE;
            end
        endcase

        // register writes; bit 3 of secondary forced zero
        // status clears by writing ones
        if (reg_wr) begin
            case (reg_addr)
                tlic_pkg::ADDR_IE_MAIN: s_d.ie_main = reg_wdata;
                tlic_pkg::ADDR_IE_SEC:  s_d.ie_sec  = wmask(reg_wdata, tlic_pkg::MASK_IE_SEC); // RULE5
                tlic_pkg::ADDR_IP_MAIN: s_d.ip_main = wmask(reg_wdata, tlic_pkg::MASK_IP_MAIN);
                tlic_pkg::ADDR_STATUS:  s_d.status  = s_q.status & ~reg_wdata;
                tlic_pkg::ADDR_MASK:    s_d.mask    = wmask(reg_wdata, tlic_pkg::MASK_STATUS);
                default: ;
            endcase
        end
        // set beats a clear in the same cycle
        s_d.status = (s_d.status | ev) & tlic_pkg::MASK_STATUS;

        // read data one cycle after the strobe; unmapped reads zero
        // reads have no side effects
        if (reg_rd) begin
            case (reg_addr)
                tlic_pkg::ADDR_IE_MAIN: s_d.rdata = s_q.ie_main;
                tlic_pkg::ADDR_IE_SEC:  s_d.rdata = s_q.ie_sec;
                tlic_pkg::ADDR_IP_MAIN: s_d.rdata = s_q.ip_main;
                tlic_pkg::ADDR_STATUS:  s_d.rdata = s_q.status;
                tlic_pkg::ADDR_MASK:    s_d.rdata = s_q.mask;
                default:                s_d.rdata = '0;
            endcase
        end
        // from next values, so the pin is a flop
        s_d.irq = |(s_d.status & s_d.mask);
    end

    // ************************************************************
    // state register
    // ************************************************************
    // clock enable freezes everything, pulses included
    // limitation: strobes stretch while clk_en is low
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            // power-on values
            s_q         <= '0;
            s_q.ie_main <= tlic_pkg::RST_IE_MAIN; // RULE6
            s_q.ie_sec  <= tlic_pkg::RST_IE_SEC;  // RULE6
            s_q.ip_main <= tlic_pkg::RST_IP_MAIN; // RULE6
            s_q.phase   <= ST_IDLE;
            s_q.src     <= tlic_pkg::SRC_NONE;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign reg_rdata      = s_q.rdata;

    // to the core
    assign irq_take       = s_q.take;
    assign push_pc        = s_q.push;
    assign vector_addr    = s_q.vec;
    assign src_index      = s_q.src;
    assign wdog_reset_req = s_q.wdrst;

    // levels and the level interrupt
    assign in_high        = s_q.act_hi;
    assign in_low         = s_q.act_lo;
    assign irq_out        = s_q.irq;
endmodule
`default_nettype wire

/* File: tlic_top_sva.sv */
// port checker for the interrupt controller
// assumes only the top module's ports; bound below
`timescale 1ns/1ps
`default_nettype none
module tlic_chk #(
    parameter int WDOG_TW = 4
) (
    // clock and reset
    input wire logic               mclk,
    input wire logic               arst_n,
    // register port
    input wire logic [7:0]         reg_addr,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    // core side
    input wire logic [WDOG_TW-1:0] watchdog_timeout_setting,
    input wire logic               reti_pulse,
    input wire logic               irq_take,
    input wire logic               push_pc,
    input wire logic [15:0]        vector_addr,
    input wire logic [3:0]         src_index,
    input wire logic               in_high,
    input wire logic               in_low
);
    // ****
    // one clock domain
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    push_then_take_a: assert property (push_pc |=> irq_take)
        else $error("no take after push");
    push_spacing_a: assert property (push_pc |=> !push_pc [*2])
        else $error("pushes too close");
    take_vector_a: assert property (irq_take |-> vector_addr == tlic_pkg::VEC_TABLE[src_index])
        else $error("wrong vector");
    take_new_level_a: assert property (irq_take |-> $rose(in_high) || $rose(in_low))
        else $error("same level nested");
    low_under_high_a: assert property ($rose(in_low) |-> !$past(in_high))
        else $error("low taken under high");
    wdog_high_a: assert property (irq_take && int'(src_index) == tlic_pkg::S_WDOG |-> in_high)
        else $error("watchdog not high");
    wdog_zero_a: assert property (irq_take && int'(src_index) == tlic_pkg::S_WDOG
        |-> $past(watchdog_timeout_setting, 2) != '0)
        else $error("watchdog with zero setting");
    reti_release_a: assert property (reti_pulse && in_high |=> !in_high)
        else $error("high level kept");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside slot");
    sec_bit3_a: assert property (reg_rd && reg_addr == tlic_pkg::ADDR_IE_SEC |=> !reg_rdata[3])
        else $error("reserved bit read back");
endmodule
bind tlic_top tlic_chk #(.WDOG_TW(WDOG_TW)) u_tlic_chk (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .watchdog_timeout_setting(watchdog_timeout_setting),
    .reti_pulse(reti_pulse), .irq_take(irq_take), .push_pc(push_pc),
    .vector_addr(vector_addr), .src_index(src_index), .in_high(in_high), .in_low(in_low));
`default_nettype wire

/* File: tlic_top_test.sv */
// self-checking bench for the interrupt controller
// assumes package, design, checker and core model compiled first
`timescale 1ns/1ps
`default_nettype none
module tlic_top_test;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [10:0] fl = '0;
    logic        alt = 1'b0;
    logic        wmode = 1'b1;
    logic [3:0]  wset = 4'h3;
    logic        ret_req = 1'b0;
    logic        stall = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  reg_rdata;
    logic [15:0] vector_addr;
    logic [3:0]  src_index, depth;
    logic        core_ready, reti_pulse, irq_take, push_pc, wdog_rst, in_high, in_low, irq_out;
    int          n_errors = 0;
    int          n_compared = 0;
    // expected vectors in poll order
    logic [15:0] vec [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
                              16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    tlic_top u_tlic_top (.mclk(mclk), .arst_n(arst_n), .clk_en(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .supply_monitor_flag(fl[0]), .watchdog_timeout_flag(fl[1]),
        .watchdog_interrupt_mode(wmode), .watchdog_timeout_setting(wset),
        .ext0_request_flag(fl[2]), .primary_adc_ready_flag(fl[3] & ~alt),
        .aux_adc_ready_flag(fl[3] & alt), .timer0_overflow_flag(fl[4]),
        .ext1_request_flag(fl[5]), .timer1_overflow_flag(fl[6]),
        .spi_transfer_flag(fl[7] & ~alt), .twowire_transfer_flag(fl[7] & alt),
        .uart_rx_done_flag(fl[8] & ~alt), .uart_tx_done_flag(fl[8] & alt),
        .timer2_overflow_flag(fl[9] & ~alt), .timer2_external_flag(fl[9] & alt),
        .interval_counter_flag(fl[10]), .core_ready(core_ready), .reti_pulse(reti_pulse),
        .irq_take(irq_take), .push_pc(push_pc), .vector_addr(vector_addr),
        .src_index(src_index), .wdog_reset_req(wdog_rst), .in_high(in_high),
        .in_low(in_low), .irq_out(irq_out));
    tlic_core_model u_tlic_core_model (.mclk(mclk), .arst_n(arst_n), .ret_req(ret_req),
        .stall(stall), .push_pc(push_pc), .core_ready(core_ready),
        .reti_pulse(reti_pulse), .depth(depth));
    // ****
    // shared tasks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask
    // bounded wait for a take, then the core clears the flag
    task automatic take(input int k);
        int n;
        n = 0;
        @(negedge mclk);
        while (irq_take !== 1'b1 && n < 30) begin
            @(negedge mclk);
            n++;
        end
        chk({15'h0, irq_take}, 16'h1);
        chk({12'h0, src_index}, k[15:0]);
        chk(vector_addr, vec[k]);
        @(posedge mclk);
        fl[k] <= 1'b0;
    endtask
    task automatic quiet(input int n);
        repeat (n) @(negedge mclk) chk({15'h0, irq_take}, 16'h0);
    endtask
    task automatic ret();
        @(posedge mclk);
        ret_req <= 1'b1;
        @(posedge mclk);
        ret_req <= 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic lvl(input logic [15:0] e);
        @(negedge mclk);
        chk({14'h0, in_high, in_low}, e);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // hang guard at 20000 cycles, far beyond the few hundred cycles needed
    initial begin
        #100000;
        n_errors++;
        tally_and_finish();
    end
    // ****
    // main sequence
    // ****
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        rd(8'ha8, 8'h00);
        rd(8'ha9, 8'ha0);
        rd(8'hb8, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h7f);
        wr(8'ha9, 8'h77);
        rd(8'ha9, 8'h77);
        wr(8'hb8, 8'h00);
        wr(8'ha9, 8'h07);
        wr(8'ha8, 8'hff);
        rd(8'ha8, 8'hff);
        // rows: one source each, paired flags alternate
        for (int k = 0; k < 11; k++) begin
            @(posedge mclk);
            fl[k] <= 1'b1;
            alt <= k[0];
            take(k);
            lvl((k == 1) ? 16'h2 : 16'h1);
            ret();
            lvl(16'h0);
        end
        // all at once: watchdog high first, then poll order
        @(posedge mclk);
        fl <= 11'h7ff;
        for (int k = 0; k < 11; k++) begin
            take((k < 2) ? 1 - k : k);
            ret();
        end
        // high preempts low, same level waits
        wr(8'hb8, 8'h01);
        @(posedge mclk);
        fl[4] <= 1'b1;
        take(4);
        @(posedge mclk);
        fl[6] <= 1'b1;
        quiet(6);
        @(posedge mclk);
        fl[2] <= 1'b1;
        take(2);
        lvl(16'h3);
        ret();
        lvl(16'h1);
        quiet(4);
        ret();
        take(6);
        ret();
        // status: raised, masked, cleared
        rd(8'hc0, 8'h07);
        chk({15'h0, irq_out}, 16'h0);
        wr(8'hc1, 8'h07);
        repeat (2) @(negedge mclk);
        chk({15'h0, irq_out}, 16'h1);
        wr(8'hc0, 8'h07);
        repeat (2) @(negedge mclk);
        chk({15'h0, irq_out}, 16'h0);
        // same cycle, high level wins over poll order
        wr(8'hb8, 8'h20);
        @(posedge mclk);
        fl <= 11'h204;
        take(9);
        ret();
        take(2);
        ret();
        // watchdog ignores the global enable; slow core first
        wr(8'ha8, 8'h00);
        @(posedge mclk);
        stall <= 1'b1;
        fl[1] <= 1'b1;
        quiet(4);
        @(posedge mclk);
        stall <= 1'b0;
        take(1);
        lvl(16'h2);
        ret();
        @(posedge mclk);
        wset <= 4'h0;
        fl[1] <= 1'b1;
        quiet(6);
        @(posedge mclk);
        wset <= 4'h3;
        wmode <= 1'b0;
        repeat (3) @(negedge mclk);
        chk({15'h0, wdog_rst}, 16'h1);
        @(posedge mclk);
        wmode <= 1'b1;
        take(1);
        chk({15'h0, wdog_rst}, 16'h0);
        ret();
        // a low clock enable drops a write
        @(posedge mclk);
        ce <= 1'b0;
        wr(8'ha8, 8'h5a);
        ce <= 1'b1;
        rd(8'ha8, 8'h00);
        chk({12'h0, depth}, 16'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
